// file: rtl/flctl_pkg.sv
// Constants for the flash LED control register bank.
// Assumes a 10 MHz system clock and a byte-wide register port.
package flctl_pkg;
	// ----------------------------------------
	// Bus addressing
	// ----------------------------------------
	localparam logic [7:0] ADDR_BYTE_WR = 8'h60;
	localparam logic [7:0] ADDR_BYTE_RD = 8'h61;
	localparam logic [7:0] OFS_DESIGN_INFO = 8'h00;
	localparam logic [7:0] OFS_PIN_TIMER = 8'h02;
	localparam logic [7:0] OFS_CURRENT = 8'h03;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_PIN_TIMER = 8'h0f;
	localparam logic [7:0] RST_CURRENT = 8'h73;
	localparam logic [7:0] RST_MODE = 8'ha4;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_PIN_TWO = 6;
	localparam int POS_PIN_ONE = 4;
	localparam int POS_TIMEOUT = 0;
	localparam int POS_FLASH_I = 3;
	localparam int POS_TORCH_I = 0;
	localparam int POS_PEAK = 6;
	localparam int POS_TRIG_LEVEL = 5;
	localparam int POS_FOLDBACK = 4;
	localparam int POS_OUT_EN = 3;
	localparam int POS_TRIG_SRC = 2;
	localparam int POS_LED_MODE = 0;
	// ----------------------------------------
	// Field codes and scaling
	// ----------------------------------------
	typedef enum logic [1:0] {
		LED_STANDBY = 2'b00,
		LED_VOLTAGE = 2'b01,
		LED_ASSIST = 2'b10,
		LED_FLASH = 2'b11
	} flctl_led_mode_t;
	localparam logic [1:0] PIN_HIZ = 2'h0;
	localparam logic [1:0] PIN_ONE_RESERVED = 2'h3;
	localparam logic [4:0] FLASH_CODE_MAX = 5'h18;
	localparam logic [10:0] FLASH_MA_BASE = 11'h12c;
	localparam logic [10:0] FLASH_MA_STEP = 11'h032;
	localparam logic [7:0] TORCH_MA_STEP = 8'h19;
	localparam logic [10:0] TIMEOUT_MS_STEP = 11'h064;
	localparam logic [11:0] PEAK_MA_0 = 12'h6d6;
	localparam logic [11:0] PEAK_MA_1 = 12'h8ca;
	localparam logic [11:0] PEAK_MA_2 = 12'habe;
	localparam logic [11:0] PEAK_MA_3 = 12'hbb8;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int TIMEOUT_STEP_MS = 100;
	localparam int TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_MS * (CLK_HZ / 1000);
	localparam int STEP_CNT_W = 24;
endpackage

// file: rtl/flctl_regs.sv
// Flash LED driver control registers with byte-wide register port.
// Assumes the serial front end runs on clk; pins arrive asynchronously.
// How it works
// - Bit 0 is the least significant, bit 7 the most, everywhere.
// - Offset 0x00 reads a fixed design code; writes there are dropped.
// - Offset 0x02 bits 7:6 pick pin two function; high impedance default.
// - Bits 5:4 pick pin one function; high impedance by default.
// - Bits 3:0 give flash timeout, 100 ms per step, default 1600 ms.
// - Offset 0x03 bits 2:0 give torch current, 25 mA steps, default code 011.
// - Offset 0x04 bits 7:6 select inductor peak limit, default 2.75 A.
// - Bit 5 chooses edge or level trigger; level by default.
// - Bit 4 allows frequency foldback; not allowed by default.
// - Bit 3 turns the output on; off after reset.
// - Bit 2 low flashes on enable; high waits for the trigger pin.
// - Bits 1:0 choose standby, 5 V, assist light or flash.
// - A critical fault clears the output enable bit.
// - Rising edge on the enable pin restores every register default.
// - Only address byte 0x60 writes and 0x61 reads are answered.
`timescale 1ns/100ps
module flctl_regs
	import flctl_pkg::*;
#(
	parameter logic [7:0] DESIGN_CODE = 8'h5a, // Arbitrary value
	parameter int STEP_CYCLES = TIMEOUT_STEP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic bus_req,
	input wire logic [7:0] bus_addr_byte,
	input wire logic [7:0] bus_sub_addr,
	input wire logic [7:0] bus_wdata,
	output logic bus_ack,
	output logic [7:0] bus_rdata,
	// Pins
	input wire logic enable_pin,
	input wire logic trigger_pin,
	input wire logic critical_fault,
	// Configuration to the analog side
	output logic [1:0] pin_two_function,
	output logic [1:0] pin_one_function,
	output logic [10:0] flash_timeout_ms,
	output logic [10:0] flash_current_ma,
	output logic [7:0] torch_current_ma,
	output logic [11:0] inductor_peak_ma,
	output logic switching_foldback_allow,
	output logic output_on,
	output logic [1:0] led_operating_mode,
	output logic flash_active
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] en_sync_r, en_sync_nxt;
	logic [1:0] trig_sync_r, trig_sync_nxt;
	logic [1:0] flt_sync_r, flt_sync_nxt;
	logic en_prev_r, en_prev_nxt;
	logic trig_prev_r, trig_prev_nxt;
	logic en_rise, trig_rise, fault_s, trig_s;

	always_comb begin
		en_sync_nxt = {en_sync_r[0], enable_pin};
		trig_sync_nxt = {trig_sync_r[0], trigger_pin};
		flt_sync_nxt = {flt_sync_r[0], critical_fault};
		en_prev_nxt = en_sync_r[1];
		trig_prev_nxt = trig_sync_r[1];
	end

	// Enable idles high; a low reset value would fake a rise after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			en_sync_r <= 2'h3;
			trig_sync_r <= 2'h0;
			flt_sync_r <= 2'h0;
			en_prev_r <= 1'b1;
			trig_prev_r <= 1'b0;
		end else begin
			en_sync_r <= en_sync_nxt;
			trig_sync_r <= trig_sync_nxt;
			flt_sync_r <= flt_sync_nxt;
			en_prev_r <= en_prev_nxt;
			trig_prev_r <= trig_prev_nxt;
		end
	end

	assign en_rise = en_sync_r[1] & ~en_prev_r;
	assign trig_s = trig_sync_r[1];
	assign trig_rise = trig_s & ~trig_prev_r;
	assign fault_s = flt_sync_r[1];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] pin_tmr_r, pin_tmr_nxt;
	logic [7:0] cur_r, cur_nxt;
	logic [7:0] mode_r, mode_nxt;
	logic ack_r, ack_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic wr_hit, rd_hit, timeout_hit, trig_src_hw;
	logic [4:0] fl_code;

	assign wr_hit = bus_req && (bus_addr_byte == ADDR_BYTE_WR);
	assign rd_hit = bus_req && (bus_addr_byte == ADDR_BYTE_RD);
	assign trig_src_hw = mode_r[POS_TRIG_SRC];

	always_comb begin
		pin_tmr_nxt = pin_tmr_r;
		cur_nxt = cur_r;
		mode_nxt = mode_r;
		ack_nxt = wr_hit | rd_hit;
		rdata_nxt = rdata_r;
		if (wr_hit) begin
			unique case (bus_sub_addr)
				OFS_PIN_TIMER: pin_tmr_nxt = bus_wdata;
				OFS_CURRENT: cur_nxt = bus_wdata;
				OFS_MODE: mode_nxt = bus_wdata;
				default: pin_tmr_nxt = pin_tmr_r;
			endcase
		end
		if (rd_hit) begin
			unique case (bus_sub_addr)
				OFS_DESIGN_INFO: rdata_nxt = DESIGN_CODE;
				OFS_PIN_TIMER: rdata_nxt = pin_tmr_r;
				OFS_CURRENT: rdata_nxt = cur_r;
				OFS_MODE: rdata_nxt = mode_r;
				default: rdata_nxt = RD_UNMAPPED;
			endcase
		end
		if (fault_s || timeout_hit) begin
			mode_nxt[POS_OUT_EN] = 1'b0;
		end
		if (en_rise) begin
			pin_tmr_nxt = RST_PIN_TIMER;
			cur_nxt = RST_CURRENT;
			mode_nxt = RST_MODE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pin_tmr_r <= RST_PIN_TIMER;
			cur_r <= RST_CURRENT;
			mode_r <= RST_MODE;
			ack_r <= 1'b0;
			rdata_r <= RD_UNMAPPED;
		end else begin
			pin_tmr_r <= pin_tmr_nxt;
			cur_r <= cur_nxt;
			mode_r <= mode_nxt;
			ack_r <= ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign bus_ack = ack_r;
	assign bus_rdata = rdata_r;

	// ----------------------------------------
	// Flash sequencer
	// ----------------------------------------
	typedef enum logic {
		FL_IDLE = 1'b0,
		FL_ON = 1'b1
	} flctl_flash_t;
	flctl_flash_t fl_state_r, fl_state_nxt;
	logic [STEP_CNT_W-1:0] step_cnt_r, step_cnt_nxt;
	logic [3:0] step_num_r, step_num_nxt;
	logic armed, start, step_end;

	assign armed = mode_r[POS_OUT_EN] &&
		(mode_r[POS_LED_MODE +: 2] == LED_FLASH);
	assign start = armed && (!trig_src_hw ||
		(mode_r[POS_TRIG_LEVEL] ? trig_s : trig_rise));
	assign step_end = step_cnt_r == STEP_CNT_W'(STEP_CYCLES - 1);
	// timeout after code plus one steps
	assign timeout_hit = (fl_state_r == FL_ON) && step_end &&
		(step_num_r == pin_tmr_r[POS_TIMEOUT +: 4]);

	always_comb begin
		fl_state_nxt = fl_state_r;
		step_cnt_nxt = step_cnt_r;
		step_num_nxt = step_num_r;
		unique case (fl_state_r)
			FL_IDLE: begin
				step_cnt_nxt = '0;
				step_num_nxt = 4'h0;
				if (start) begin
					fl_state_nxt = FL_ON;
				end
			end
			FL_ON: begin
				step_cnt_nxt = step_end ? '0 : step_cnt_r + 1'b1;
				step_num_nxt = step_end ? step_num_r + 4'h1 : step_num_r;
				// Level mode ends with the pin; a lost enable ends all
				if (!armed || timeout_hit ||
					(trig_src_hw && mode_r[POS_TRIG_LEVEL] && !trig_s)) begin
					fl_state_nxt = FL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fl_state_r <= FL_IDLE;
			step_cnt_r <= '0;
			step_num_r <= 4'h0;
		end else begin
			fl_state_r <= fl_state_nxt;
			step_cnt_r <= step_cnt_nxt;
			step_num_r <= step_num_nxt;
		end
	end

	assign flash_active = fl_state_r == FL_ON;

	// ----------------------------------------
	// Decoded settings
	// ----------------------------------------
	logic [10:0] to_ms_r, to_ms_nxt, fl_ma_r, fl_ma_nxt;
	logic [7:0] tor_ma_r, tor_ma_nxt;
	logic [11:0] peak_r, peak_nxt;
	logic [1:0] p1_r, p1_nxt;

	assign fl_code = cur_r[POS_FLASH_I +: 5];

	always_comb begin
		to_ms_nxt = TIMEOUT_MS_STEP * (11'(pin_tmr_r[POS_TIMEOUT +: 4]) + 11'h1);
		fl_ma_nxt = FLASH_MA_BASE + FLASH_MA_STEP *
			11'((fl_code > FLASH_CODE_MAX) ? FLASH_CODE_MAX : fl_code);
		tor_ma_nxt = TORCH_MA_STEP * (8'(cur_r[POS_TORCH_I +: 3]) + 8'h1);
		unique case (mode_r[POS_PEAK +: 2])
			2'h0: peak_nxt = PEAK_MA_0;
			2'h1: peak_nxt = PEAK_MA_1;
			2'h2: peak_nxt = PEAK_MA_2;
			2'h3: peak_nxt = PEAK_MA_3;
		endcase
		p1_nxt = pin_tmr_r[POS_PIN_ONE +: 2];
		if (p1_nxt == PIN_ONE_RESERVED) begin
			p1_nxt = PIN_HIZ;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			to_ms_r <= '0;
			fl_ma_r <= '0;
			tor_ma_r <= '0;
			peak_r <= '0;
			p1_r <= PIN_HIZ;
		end else begin
			to_ms_r <= to_ms_nxt;
			fl_ma_r <= fl_ma_nxt;
			tor_ma_r <= tor_ma_nxt;
			peak_r <= peak_nxt;
			p1_r <= p1_nxt;
		end
	end

	assign pin_two_function = pin_tmr_r[POS_PIN_TWO +: 2];
	assign pin_one_function = p1_r;
	assign flash_timeout_ms = to_ms_r;
	assign flash_current_ma = fl_ma_r;
	assign torch_current_ma = tor_ma_r;
	assign inductor_peak_ma = peak_r;
	assign switching_foldback_allow = mode_r[POS_FOLDBACK];
	assign output_on = mode_r[POS_OUT_EN];
	assign led_operating_mode = mode_r[POS_LED_MODE +: 2];

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_id_read;
		@(posedge clk) disable iff (reset)
		rd_hit && bus_sub_addr == OFS_DESIGN_INFO |=> bus_rdata == DESIGN_CODE;
	endproperty
	a_id_read: assert property (p_id_read) else $error("id read wrong");
	property p_fault_clears;
		@(posedge clk) disable iff (reset)
		fault_s && !en_rise |=> !output_on;
	endproperty
	a_fault_clears: assert property (p_fault_clears) else $error("fault kept on");
	property p_en_defaults;
		@(posedge clk) disable iff (reset)
		en_rise |=> mode_r == RST_MODE && cur_r == RST_CURRENT &&
			pin_tmr_r == RST_PIN_TIMER;
	endproperty
	a_en_defaults: assert property (p_en_defaults) else $error("no defaults");
	property p_bad_addr;
		@(posedge clk) disable iff (reset)
		bus_req && bus_addr_byte != ADDR_BYTE_WR &&
			bus_addr_byte != ADDR_BYTE_RD && !fault_s && !timeout_hit &&
			!en_rise |=> !bus_ack && $stable(mode_r);
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("foreign address");
	property p_flash_clamp;
		@(posedge clk) disable iff (reset)
		fl_code > FLASH_CODE_MAX |=> flash_current_ma ==
			FLASH_MA_BASE + FLASH_MA_STEP * 11'(FLASH_CODE_MAX);
	endproperty
	a_flash_clamp: assert property (p_flash_clamp) else $error("no clamp");
	property p_pin_one_res;
		@(posedge clk) disable iff (reset)
		pin_tmr_r[POS_PIN_ONE +: 2] == PIN_ONE_RESERVED |=>
			pin_one_function == PIN_HIZ || $changed(pin_tmr_r);
	endproperty
	a_pin_one_res: assert property (p_pin_one_res) else $error("pin one on");
	property p_sw_start;
		@(posedge clk) disable iff (reset)
		armed && !trig_src_hw && fl_state_r == FL_IDLE |=> flash_active;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("no sw flash");
	property p_edge_start;
		@(posedge clk) disable iff (reset)
		fl_state_r == FL_IDLE && armed && trig_src_hw &&
			!mode_r[POS_TRIG_LEVEL] && !trig_rise |=> !flash_active;
	endproperty
	a_edge_start: assert property (p_edge_start) else $error("edge misfire");
	property p_no_out_no_flash;
		@(posedge clk) disable iff (reset)
		!output_on ##1 !output_on |-> !flash_active;
	endproperty
	a_no_out_no_flash: assert property (p_no_out_no_flash) else $error("flash off");
	c_sw_flash: cover property (@(posedge clk) disable iff (reset)
		!trig_src_hw && $rose(flash_active));
	c_timeout: cover property (@(posedge clk) disable iff (reset) timeout_hit);
	c_en_rise: cover property (@(posedge clk) disable iff (reset) en_rise);
endmodule

// file: bench/flctl_host_model.sv
// Host model: single byte accesses toward the flash control bank.
// Assumes a shared clock; ack comes the cycle after the taking edge.
`timescale 1ns/100ps
module flctl_host_model
	import flctl_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register port
	output logic bus_req,
	output logic [7:0] bus_addr_byte,
	output logic [7:0] bus_sub_addr,
	output logic [7:0] bus_wdata,
	input wire logic bus_ack,
	input wire logic [7:0] bus_rdata
);
	initial begin
		bus_req = 1'b0;
		bus_addr_byte = 8'hff;
		bus_sub_addr = 8'h00;
		bus_wdata = 8'h00;
	end
	// ----------------------------------------
	// Byte access
	// ----------------------------------------
	// Request is a one cycle pulse; a longer one is taken twice
	task automatic access(input logic [7:0] abyte, input logic [7:0] ofs,
		input logic [7:0] wd, output logic acked, output logic [7:0] rd);
		int n;
		acked = 1'b0;
		rd = 8'h00;
		@(posedge clk);
		bus_req <= 1'b1;
		bus_addr_byte <= abyte;
		bus_sub_addr <= ofs;
		bus_wdata <= wd;
		@(posedge clk);
		// Released lines show the inverse, never the old value
		bus_req <= 1'b0;
		bus_addr_byte <= ~abyte;
		bus_sub_addr <= ~ofs;
		bus_wdata <= ~wd;
		for (n = 0; n < 3 && !acked; n++) begin
			#1;
			if (bus_ack === 1'b1) begin
				acked = 1'b1;
				rd = bus_rdata;
			end else begin
				@(posedge clk);
			end
		end
	endtask
endmodule

// file: bench/tb_flctl_regs.sv
// Self-checking bench for the flash LED control register bank.
// Assumes the host model owns the register port; pins are driven here.
`timescale 1ns/100ps
module tb_flctl_regs
	import flctl_pkg::*;
;
	localparam logic [7:0] ID_CODE = 8'h3c; // Arbitrary value
	localparam int STEP = 10;
	localparam int FLC [4] = '{0, 24, 25, 31};
	localparam int PEAK [4] = '{1750, 2250, 2750, 3000};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic enable_pin = 1'b1;
	logic trigger_pin = 1'b0;
	logic critical_fault = 1'b0;
	logic bus_req, bus_ack, output_on, fold, flash_active;
	logic [7:0] addr_byte, sub_addr, wdata, rdata, torch_ma;
	logic [1:0] pin_two, pin_one, led_mode;
	logic [10:0] tmo_ms, flash_ma;
	logic [11:0] peak_ma;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #50 clk = ~clk;
	flctl_host_model i_host (.clk(clk), .bus_req(bus_req),
		.bus_addr_byte(addr_byte), .bus_sub_addr(sub_addr),
		.bus_wdata(wdata), .bus_ack(bus_ack), .bus_rdata(rdata));
	flctl_regs #(.DESIGN_CODE(ID_CODE), .STEP_CYCLES(STEP)) i_dut (
		.clk(clk), .reset(reset), .bus_req(bus_req),
		.bus_addr_byte(addr_byte), .bus_sub_addr(sub_addr),
		.bus_wdata(wdata), .bus_ack(bus_ack), .bus_rdata(rdata),
		.enable_pin(enable_pin), .trigger_pin(trigger_pin),
		.critical_fault(critical_fault), .pin_two_function(pin_two),
		.pin_one_function(pin_one), .flash_timeout_ms(tmo_ms),
		.flash_current_ma(flash_ma), .torch_current_ma(torch_ma),
		.inductor_peak_ma(peak_ma), .switching_foldback_allow(fold),
		.output_on(output_on), .led_operating_mode(led_mode),
		.flash_active(flash_active));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
		logic ack;
		logic [7:0] d;
		i_host.access(ADDR_BYTE_WR, ofs, wd, ack, d);
		chk("write ack", 16'h1, {15'h0, ack});
	endtask
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		logic ack;
		logic [7:0] d;
		i_host.access(ADDR_BYTE_RD, ofs, 8'h00, ack, d);
		chk("read ack", 16'h1, {15'h0, ack});
		chk("read data", {8'h0, exp}, {8'h0, d});
	endtask
	// Checks land 1 ns after the edge so updates have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		logic ack;
		logic [7:0] d;
		int i;
		int c;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		cyc(2);
		chk("pin two", 16'h0, {14'h0, pin_two});
		chk("pin one", 16'h0, {14'h0, pin_one});
		chk("timeout", 16'h0640, {5'h0, tmo_ms});
		chk("flash ma", 16'h03e8, {5'h0, flash_ma});
		chk("torch ma", 16'h0064, {8'h0, torch_ma});
		chk("peak ma", 16'h0abe, {4'h0, peak_ma});
		chk("foldback", 16'h0, {15'h0, fold});
		chk("output on", 16'h0, {15'h0, output_on});
		chk("led mode", 16'h0, {14'h0, led_mode});
		rd(OFS_DESIGN_INFO, ID_CODE);
		rd(OFS_PIN_TIMER, 8'h0f);
		rd(OFS_CURRENT, 8'h73);
		rd(OFS_MODE, 8'ha4);
		wr(OFS_DESIGN_INFO, 8'hff);
		rd(OFS_DESIGN_INFO, ID_CODE);
		rd(8'h01, 8'h00);
		i_host.access(8'h62, OFS_CURRENT, 8'h00, ack, d);
		chk("foreign ack", 16'h0, {15'h0, ack});
		rd(OFS_CURRENT, 8'h73);
		for (i = 0; i < 4; i++) begin
			c = 5 * i;
			wr(OFS_PIN_TIMER, 8'(i * 80 + c));
			cyc(2);
			chk("pin two", 16'(i), {14'h0, pin_two});
			chk("pin one", 16'(i == 3 ? 0 : i), {14'h0, pin_one});
			chk("timeout", 16'(100 * (c + 1)), {5'h0, tmo_ms});
			rd(OFS_PIN_TIMER, 8'(i * 80 + c));
			c = FLC[i] > 24 ? 24 : FLC[i];
			wr(OFS_CURRENT, 8'(FLC[i] * 8 + 7 - 2 * i));
			cyc(2);
			chk("flash ma", 16'(300 + 50 * c), {5'h0, flash_ma});
			chk("torch ma", 16'(25 * (8 - 2 * i)), {8'h0, torch_ma});
			wr(OFS_MODE, 8'(i * 64 + 32 * (i % 2) + 16 * (i / 2) + 4 + i));
			cyc(2);
			chk("peak ma", 16'(PEAK[i]), {4'h0, peak_ma});
			chk("foldback", 16'(i / 2), {15'h0, fold});
			chk("led mode", 16'(i), {14'h0, led_mode});
			chk("flashing", 16'h0, {15'h0, flash_active});
		end
		wr(OFS_PIN_TIMER, 8'h00);
		wr(OFS_MODE, 8'h0b);
		cyc(2);
		chk("output on", 16'h1, {15'h0, output_on});
		chk("flashing", 16'h1, {15'h0, flash_active});
		cyc(STEP - 2);
		chk("flashing", 16'h1, {15'h0, flash_active});
		cyc(1);
		chk("flashing", 16'h0, {15'h0, flash_active});
		chk("output on", 16'h0, {15'h0, output_on});
		rd(OFS_MODE, 8'h03);
		wr(OFS_MODE, 8'h2f);
		cyc(5);
		chk("flashing", 16'h0, {15'h0, flash_active});
		@(posedge clk) trigger_pin <= 1'b1;
		cyc(5);
		chk("flashing", 16'h1, {15'h0, flash_active});
		@(posedge clk) trigger_pin <= 1'b0;
		cyc(5);
		chk("flashing", 16'h0, {15'h0, flash_active});
		chk("output on", 16'h1, {15'h0, output_on});
		@(posedge clk) critical_fault <= 1'b1;
		cyc(5);
		chk("output on", 16'h0, {15'h0, output_on});
		@(posedge clk) critical_fault <= 1'b0;
		rd(OFS_MODE, 8'h27);
		// Edge mode: a short pulse starts a flash that runs to timeout
		wr(OFS_MODE, 8'h0f);
		cyc(3);
		chk("flashing", 16'h0, {15'h0, flash_active});
		@(posedge clk) trigger_pin <= 1'b1;
		@(posedge clk) trigger_pin <= 1'b0;
		cyc(4);
		chk("flashing", 16'h1, {15'h0, flash_active});
		cyc(STEP);
		chk("flashing", 16'h0, {15'h0, flash_active});
		chk("output on", 16'h0, {15'h0, output_on});
		wr(OFS_CURRENT, 8'hff);
		rd(OFS_CURRENT, 8'hff);
		@(posedge clk) enable_pin <= 1'b0;
		cyc(4);
		@(posedge clk) enable_pin <= 1'b1;
		cyc(6);
		rd(OFS_CURRENT, 8'h73);
		rd(OFS_MODE, 8'ha4);
		rd(OFS_PIN_TIMER, 8'h0f);
		give_verdict();
	end
endmodule
